// [bcx_pkg.sv]
// Purpose: shared constants and types for the five-instruction exec core
// Assumes: 8-bit data memory, 16-bit program words, 21-bit byte pc
// Notes:   register offsets are byte addresses on a 32-bit apb bus
package bcx_pkg;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_FLAGS = 8'h04;
  localparam logic [7:0] ADDR_WREG = 8'h08;
  localparam logic [7:0] ADDR_BANK_SEL = 8'h0c;
  localparam logic [7:0] ADDR_PC = 8'h10;
  localparam logic [7:0] ADDR_STACK_TOP = 8'h14;
  localparam logic [7:0] ADDR_SHADOW = 8'h18;
  localparam logic [7:0] ADDR_INDEX_BASE = 8'h1c;

  // ----------------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------------
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_EXT_BIT = 1;
  localparam int FLAG_Z_BIT = 2;
  localparam int FLAG_OV_BIT = 3;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [4:0] FLAGS_RST = 5'h00;
  localparam logic [7:0] WREG_RST = 8'h00;
  localparam logic [3:0] BANK_SEL_RST = 4'h0;
  localparam logic [11:0] INDEX_BASE_RST = 12'h000;
  localparam logic [20:0] PC_RST = 21'h000000;
  localparam logic [20:0] PC_STEP = 21'h000002;
  localparam logic [15:0] IR_NOP = 16'h0000;

  // ----------------------------------------------------------------------
  // opcodes and addressing
  // ----------------------------------------------------------------------
  localparam logic [3:0] OPC_BIT_INVERT = 4'h7;
  localparam logic [7:0] OPC_BRANCH_OV = 8'he4;
  localparam logic [7:0] OPC_BRANCH_Z = 8'he0;
  localparam logic [6:0] OPC_CALL = 7'h76;
  localparam logic [3:0] OPC_CALL_SECOND = 4'hf;
  localparam logic [6:0] OPC_CLEAR = 7'h35;
  localparam logic [7:0] ACCESS_LIMIT = 8'h5f;
  localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hf;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    Q1 = 2'b00,
    Q2 = 2'b01,
    Q3 = 2'b11,
    Q4 = 2'b10
  } bcx_q_t;

  typedef struct packed {
    logic [20:0] addr;
    logic re;
  } bcx_pmem_req_t;

  typedef struct packed {
    logic [11:0] addr;
    logic [7:0] wdata;
    logic re;
    logic we;
  } bcx_dmem_req_t;

endpackage

// [bcx_qphase.sv]
// Purpose: quarter-phase sequencer, one quarter per clock
// Assumes: run may drop at any time
// Notes:   a started instruction cycle always runs to its fourth quarter
`timescale 1ns/1ps
`default_nettype none
module bcx_qphase (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // control
  input wire logic run_i,
  // phase
  output bcx_pkg::bcx_q_t phase_o
);

  bcx_pkg::bcx_q_t phase_ff;
  bcx_pkg::bcx_q_t nxt_phase;

  always_comb begin
    nxt_phase = phase_ff;
    if (run_i || phase_ff != bcx_pkg::Q1) begin
      case (phase_ff)
        bcx_pkg::Q1: nxt_phase = bcx_pkg::Q2;
        bcx_pkg::Q2: nxt_phase = bcx_pkg::Q3;
        bcx_pkg::Q3: nxt_phase = bcx_pkg::Q4;
        bcx_pkg::Q4: nxt_phase = bcx_pkg::Q1;
        default: nxt_phase = bcx_pkg::Q1;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      phase_ff <= bcx_pkg::Q1;
    end else begin
      phase_ff <= nxt_phase;
    end
  end

  assign phase_o = phase_ff;

endmodule
`default_nettype wire

// [bcx_addr_gen.sv]
// Purpose: data memory address from an 8-bit location operand
// Assumes: 16 banks of 256 bytes, 12-bit data address
// Notes:   purely combinational
`timescale 1ns/1ps
`default_nettype none
module bcx_addr_gen (
  // operand
  input wire logic [7:0] loc_i,
  input wire logic bank_mode_i,
  // configuration
  input wire logic ext_en_i,
  input wire logic [3:0] bank_sel_i,
  input wire logic [11:0] index_base_i,
  // result
  output logic [11:0] addr_o
);

  always_comb begin
    if (bank_mode_i) begin
      addr_o = {bank_sel_i, loc_i};
    end else if (ext_en_i && loc_i <= bcx_pkg::ACCESS_LIMIT) begin
      addr_o = index_base_i + {4'h0, loc_i};
    end else if (loc_i <= bcx_pkg::ACCESS_LIMIT) begin
      addr_o = {bcx_pkg::ACCESS_LO_BANK, loc_i};
    end else begin
      addr_o = {bcx_pkg::ACCESS_HI_BANK, loc_i};
    end
  end

endmodule
`default_nettype wire

// [bcx_exec_core.sv]
// Purpose: fetch, decode and execute of five core instructions
// Assumes: memories answer in the same clock as the request
// Notes:   registers reached over apb, zero wait states
//
// Operation
// - bit invert flips one bit, flags untouched
// - access bit selects access or selected bank
// - extended mode indexes locations up to 5fh
// - bit invert reads q2, processes q3, writes q4
// - overflow branch taken only on overflow flag
// - zero branch taken only on zero flag
// - branch target is pc plus twice offset
// - taken branch two cycles, else one
// - call pushes address after its two words
// - save flag copies working, flags, bank shadows
// - call literal loads pc bits 20 to 1
// - call decoded from first word only
// - call pushes in q3, writes pc q4
`timescale 1ns/1ps
`default_nettype none
module bcx_exec_core (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // program memory
  output bcx_pkg::bcx_pmem_req_t pmem_req_o,
  input wire logic [15:0] pmem_rdata_i,
  // data memory
  output bcx_pkg::bcx_dmem_req_t dmem_req_o,
  input wire logic [7:0] dmem_rdata_i,
  // return stack
  output logic stack_push_o,
  output logic [20:0] stack_top_o
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [20:0] branch_off(input logic [7:0] n);
    branch_off = {{12{n[7]}}, n, 1'b0};
  endfunction
  function automatic logic [7:0] bit_mask(input logic [2:0] b);
    bit_mask = 8'h01 << b;
  endfunction

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  bcx_pkg::bcx_q_t phase;
  logic [1:0] ctrl_ff, nxt_ctrl;
  logic [4:0] flags_ff, nxt_flags, flags_shadow_ff, nxt_flags_shadow;
  logic [7:0] wreg_ff, nxt_wreg, working_shadow_ff, nxt_working_shadow;
  logic [3:0] bank_sel_reg_ff, nxt_bank_sel_reg;
  logic [3:0] bank_select_shadow_ff, nxt_bank_select_shadow;
  logic [11:0] index_base_ff, nxt_index_base, data_addr;
  logic [20:0] pc_ff, nxt_pc, stack_top_ff, nxt_stack_top;
  logic [15:0] ir_ff, nxt_ir;
  logic [7:0] opnd_ff, nxt_opnd, result_ff, nxt_result;
  logic is_inv, is_bov, is_bz, is_call, is_clr, taken;
  logic wr_en, rd_hit, halted, flush_ff, nxt_flush, push_ff, nxt_push;

  bcx_qphase u_qphase (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .run_i(ctrl_ff[bcx_pkg::CTRL_RUN_BIT]),
    .phase_o(phase)
  );
  bcx_addr_gen u_addr_gen (
    .loc_i(ir_ff[7:0]),
    .bank_mode_i(ir_ff[8]),
    .ext_en_i(ctrl_ff[bcx_pkg::CTRL_EXT_BIT]),
    .bank_sel_i(bank_sel_reg_ff),
    .index_base_i(index_base_ff),
    .addr_o(data_addr)
  );

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  always_comb begin
    is_inv = !flush_ff && ir_ff[15:12] == bcx_pkg::OPC_BIT_INVERT;
    is_bov = !flush_ff && ir_ff[15:8] == bcx_pkg::OPC_BRANCH_OV;
    is_bz = !flush_ff && ir_ff[15:8] == bcx_pkg::OPC_BRANCH_Z;
    is_call = !flush_ff && ir_ff[15:9] == bcx_pkg::OPC_CALL;
    is_clr = !flush_ff && ir_ff[15:9] == bcx_pkg::OPC_CLEAR;
    taken = (is_bov && flags_ff[bcx_pkg::FLAG_OV_BIT]) ||
            (is_bz && flags_ff[bcx_pkg::FLAG_Z_BIT]);
  end

  // ----------------------------------------------------------------------
  // data path: read q2, process q3, write q4
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_opnd = opnd_ff;
    nxt_result = result_ff;
    if (phase == bcx_pkg::Q2 && is_inv) begin
      nxt_opnd = dmem_rdata_i;
    end
    if (phase == bcx_pkg::Q3) begin
      nxt_result = is_inv ? (opnd_ff ^ bit_mask(ir_ff[11:9])) : 8'h00;
    end
  end
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      opnd_ff <= 8'h00;
      result_ff <= 8'h00;
    end else begin
      opnd_ff <= nxt_opnd;
      result_ff <= nxt_result;
    end
  end

  always_comb begin
    dmem_req_o.addr = data_addr;
    dmem_req_o.wdata = result_ff;
    dmem_req_o.re = is_inv && phase == bcx_pkg::Q2;
    dmem_req_o.we = (is_inv || is_clr) && phase == bcx_pkg::Q4;
    pmem_req_o.addr = pc_ff;
    pmem_req_o.re = phase == bcx_pkg::Q4;
  end

  // ----------------------------------------------------------------------
  // core registers and apb writes
  // ----------------------------------------------------------------------
  assign wr_en = psel_i && penable_i && pwrite_i;
  assign halted = !ctrl_ff[bcx_pkg::CTRL_RUN_BIT] && phase == bcx_pkg::Q1;
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_flags = flags_ff;
    nxt_wreg = wreg_ff;
    nxt_bank_sel_reg = bank_sel_reg_ff;
    nxt_index_base = index_base_ff;
    nxt_pc = pc_ff;
    nxt_ir = ir_ff;
    nxt_flush = flush_ff;
    nxt_stack_top = stack_top_ff;
    nxt_push = 1'b0;
    nxt_working_shadow = working_shadow_ff;
    nxt_flags_shadow = flags_shadow_ff;
    nxt_bank_select_shadow = bank_select_shadow_ff;
    if (wr_en) begin
      case (paddr_i)
        bcx_pkg::ADDR_CTRL: nxt_ctrl = pwdata_i[1:0];
        bcx_pkg::ADDR_FLAGS: nxt_flags = pwdata_i[4:0];
        bcx_pkg::ADDR_WREG: nxt_wreg = pwdata_i[7:0];
        bcx_pkg::ADDR_BANK_SEL: nxt_bank_sel_reg = pwdata_i[3:0];
        bcx_pkg::ADDR_INDEX_BASE: nxt_index_base = pwdata_i[11:0];
        bcx_pkg::ADDR_PC: begin
          if (halted) begin
            nxt_pc = {pwdata_i[20:1], 1'b0};
            nxt_flush = 1'b1;
          end
        end
        default: nxt_ctrl = ctrl_ff;
      endcase
    end
    if (phase == bcx_pkg::Q3 && is_call) begin
      nxt_stack_top = pc_ff + bcx_pkg::PC_STEP;
      nxt_push = 1'b1;
      if (ir_ff[8]) begin
        nxt_working_shadow = wreg_ff;
        nxt_flags_shadow = flags_ff;
        nxt_bank_select_shadow = bank_sel_reg_ff;
      end
    end
    if (phase == bcx_pkg::Q4) begin
      nxt_ir = pmem_rdata_i;
      nxt_flush = 1'b0;
      nxt_pc = pc_ff + bcx_pkg::PC_STEP;
      if (taken) begin
        nxt_pc = pc_ff + branch_off(ir_ff[7:0]);
        nxt_flush = 1'b1;
      end else if (is_call) begin
        nxt_pc = {pmem_rdata_i[11:0], ir_ff[7:0], 1'b0};
        nxt_flush = 1'b1;
      end
      if (is_clr) begin
        nxt_flags[bcx_pkg::FLAG_Z_BIT] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_ff <= bcx_pkg::CTRL_RST;
      flags_ff <= bcx_pkg::FLAGS_RST;
      wreg_ff <= bcx_pkg::WREG_RST;
      bank_sel_reg_ff <= bcx_pkg::BANK_SEL_RST;
      index_base_ff <= bcx_pkg::INDEX_BASE_RST;
      pc_ff <= bcx_pkg::PC_RST;
      ir_ff <= bcx_pkg::IR_NOP;
      flush_ff <= 1'b1;
      stack_top_ff <= bcx_pkg::PC_RST;
      push_ff <= 1'b0;
      working_shadow_ff <= bcx_pkg::WREG_RST;
      flags_shadow_ff <= bcx_pkg::FLAGS_RST;
      bank_select_shadow_ff <= bcx_pkg::BANK_SEL_RST;
    end else begin
      ctrl_ff <= nxt_ctrl;
      flags_ff <= nxt_flags;
      wreg_ff <= nxt_wreg;
      bank_sel_reg_ff <= nxt_bank_sel_reg;
      index_base_ff <= nxt_index_base;
      pc_ff <= nxt_pc;
      ir_ff <= nxt_ir;
      flush_ff <= nxt_flush;
      stack_top_ff <= nxt_stack_top;
      push_ff <= nxt_push;
      working_shadow_ff <= nxt_working_shadow;
      flags_shadow_ff <= nxt_flags_shadow;
      bank_select_shadow_ff <= nxt_bank_select_shadow;
    end
  end
  assign stack_push_o = push_ff;
  assign stack_top_o = stack_top_ff;

  // ----------------------------------------------------------------------
  // apb read side
  // ----------------------------------------------------------------------
  always_comb begin
    rd_hit = 1'b1;
    case (paddr_i)
      bcx_pkg::ADDR_CTRL: prdata_o = 32'(ctrl_ff);
      bcx_pkg::ADDR_FLAGS: prdata_o = 32'(flags_ff);
      bcx_pkg::ADDR_WREG: prdata_o = 32'(wreg_ff);
      bcx_pkg::ADDR_BANK_SEL: prdata_o = 32'(bank_sel_reg_ff);
      bcx_pkg::ADDR_PC: prdata_o = 32'(pc_ff);
      bcx_pkg::ADDR_STACK_TOP: prdata_o = 32'(stack_top_ff);
      bcx_pkg::ADDR_SHADOW: prdata_o = 32'({bank_select_shadow_ff,
                                            flags_shadow_ff,
                                            working_shadow_ff});
      bcx_pkg::ADDR_INDEX_BASE: prdata_o = 32'(index_base_ff);
      default: begin
        prdata_o = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
  end
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && !rd_hit;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!arst_n_i);
  property p_inv_write;
    phase == bcx_pkg::Q4 && is_inv |-> dmem_req_o.we &&
      dmem_req_o.wdata == ($past(opnd_ff) ^ bit_mask(ir_ff[11:9]));
  endproperty
  a_inv_write: assert property (p_inv_write)
    else $error("bit invert wrote a wrong value");
  property p_flags_kept;
    phase == bcx_pkg::Q4 && (is_inv || is_bov || is_bz || is_call) &&
      !(wr_en && paddr_i == bcx_pkg::ADDR_FLAGS) |=> $stable(flags_ff);
  endproperty
  a_flags_kept: assert property (p_flags_kept)
    else $error("flags changed by a flag-neutral instruction");
  property p_bank_sel;
    (is_inv || is_clr) && ir_ff[8] |->
      dmem_req_o.addr == {bank_sel_reg_ff, ir_ff[7:0]};
  endproperty
  a_bank_sel: assert property (p_bank_sel)
    else $error("banked address not from bank select");
  property p_indexed;
    (is_inv || is_clr) && !ir_ff[8] && ctrl_ff[bcx_pkg::CTRL_EXT_BIT] &&
      ir_ff[7:0] <= bcx_pkg::ACCESS_LIMIT |->
      dmem_req_o.addr == index_base_ff + {4'h0, ir_ff[7:0]};
  endproperty
  a_indexed: assert property (p_indexed)
    else $error("indexed literal offset address wrong");
  property p_inv_seq;
    phase == bcx_pkg::Q2 && is_inv |-> dmem_req_o.re ##1 !dmem_req_o.we
      ##1 dmem_req_o.we;
  endproperty
  a_inv_seq: assert property (p_inv_seq)
    else $error("bit invert quarter sequence broken");
  property p_branch_target;
    phase == bcx_pkg::Q4 && taken |=>
      pc_ff == $past(pc_ff) + branch_off($past(ir_ff[7:0]));
  endproperty
  a_branch_target: assert property (p_branch_target)
    else $error("taken branch target wrong");
  property p_taken_nop;
    phase == bcx_pkg::Q4 && taken |=> flush_ff [*4];
  endproperty
  a_taken_nop: assert property (p_taken_nop)
    else $error("taken branch did not run a discard cycle");
  property p_not_taken;
    phase == bcx_pkg::Q4 && (is_bov || is_bz) && !taken |=>
      !flush_ff && pc_ff == $past(pc_ff) + bcx_pkg::PC_STEP;
  endproperty
  a_not_taken: assert property (p_not_taken)
    else $error("untaken branch redirected");
  property p_call_push;
    phase == bcx_pkg::Q3 && is_call |=> stack_push_o &&
      stack_top_o == $past(pc_ff) + bcx_pkg::PC_STEP;
  endproperty
  a_call_push: assert property (p_call_push)
    else $error("call pushed a wrong return address");
  property p_shadow_keep;
    phase == bcx_pkg::Q3 && is_call && !ir_ff[8] |=>
      $stable(working_shadow_ff) && $stable(flags_shadow_ff) &&
      $stable(bank_select_shadow_ff);
  endproperty
  a_shadow_keep: assert property (p_shadow_keep)
    else $error("shadow changed without save flag");
  property p_call_pc;
    phase == bcx_pkg::Q4 && is_call |=> flush_ff &&
      pc_ff == {$past(pmem_rdata_i[11:0]), $past(ir_ff[7:0]), 1'b0};
  endproperty
  a_call_pc: assert property (p_call_pc)
    else $error("call target wrong");
  property p_clear;
    phase == bcx_pkg::Q4 && is_clr |-> dmem_req_o.we &&
      dmem_req_o.wdata == 8'h00 ##1 flags_ff[bcx_pkg::FLAG_Z_BIT];
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear did not write zero or set zero flag");

endmodule
`default_nettype wire

// [bcx_mem_model.sv]
// Purpose: program and data memory seen by the exec core
// Assumes: both memories answer in the same clock as the request
// Notes:   unrequested read lines show the inverted word, never a stale copy
`timescale 1ns/1ps
`default_nettype none
module bcx_mem_model (
  // clock
  input wire logic clk_sys_i,
  // program memory
  input wire bcx_pkg::bcx_pmem_req_t pmem_req_i,
  output logic [15:0] pmem_rdata_o,
  // data memory
  input wire bcx_pkg::bcx_dmem_req_t dmem_req_i,
  output logic [7:0] dmem_rdata_o
);
  logic [15:0] pmem [0:1023];
  logic [7:0] dmem [0:4095];
  logic [15:0] pword;
  logic [7:0] dbyte;

  // --------------------------------------------------------------------
  // read paths
  // --------------------------------------------------------------------
  // words past the table read as an unknown opcode, which runs as a no-op
  assign pword = (pmem_req_i.addr[20:11] == 10'h000) ?
                 pmem[pmem_req_i.addr[10:1]] : 16'hffff;
  assign pmem_rdata_o = pmem_req_i.re ? pword : ~pword;
  assign dbyte = dmem[dmem_req_i.addr];
  assign dmem_rdata_o = dmem_req_i.re ? dbyte : ~dbyte;

  // --------------------------------------------------------------------
  // write path
  // --------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (dmem_req_i.we) begin
      dmem[dmem_req_i.addr] <= dmem_req_i.wdata;
    end
  end

  initial begin
    for (int i = 0; i < 1024; i++) begin
      pmem[i] = 16'h0000;
    end
    for (int i = 0; i < 4096; i++) begin
      dmem[i] = 8'h00;
    end
  end
endmodule
`default_nettype wire

// [bit_toggle_branch_call_clear_exec_bench.sv]
// Purpose: self-checking bench for the five-instruction exec core
// Assumes: zero-wait apb, memories answer in the same clock
// Notes:   programs end in a taken zero branch to itself, then halt
`timescale 1ns/1ps
`default_nettype none
module bit_toggle_branch_call_clear_exec_bench;
  logic clk_sys_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  bcx_pkg::bcx_pmem_req_t pmem_req;
  bcx_pkg::bcx_dmem_req_t dmem_req;
  logic [15:0] pmem_rdata;
  logic [7:0] dmem_rdata;
  logic stack_push_o;
  logic [20:0] stack_top_o;
  int fails = 0;
  int total_checks = 0;
  int cyc = 0;
  int pushes = 0;
  int we_q[$];

  always #4 clk_sys_i = ~clk_sys_i;

  bcx_exec_core u_dut (
    .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o),
    .pmem_req_o(pmem_req), .pmem_rdata_i(pmem_rdata),
    .dmem_req_o(dmem_req), .dmem_rdata_i(dmem_rdata),
    .stack_push_o(stack_push_o), .stack_top_o(stack_top_o)
  );

  bcx_mem_model u_mem (
    .clk_sys_i(clk_sys_i), .pmem_req_i(pmem_req),
    .pmem_rdata_o(pmem_rdata), .dmem_req_i(dmem_req),
    .dmem_rdata_o(dmem_rdata)
  );

  // --------------------------------------------------------------------
  // monitors
  // --------------------------------------------------------------------
  always @(posedge clk_sys_i) begin
    cyc++;
    if (dmem_req.we === 1'b1) begin
      we_q.push_back(cyc);
    end
    if (stack_push_o === 1'b1) begin
      pushes++;
    end
  end

  // --------------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge clk_sys_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    @(posedge clk_sys_i);
    // only the watchdog ends a wait for the answer
    while (pready_o !== 1'b1) begin
      @(posedge clk_sys_i);
    end
    r = prdata_o;
    e = pslverr_o;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp, "register read");
    chk({31'h0, e}, 32'h0, "read error");
  endtask

  task automatic halt();
    wr(bcx_pkg::ADDR_CTRL, 32'h0);
    repeat (12) @(posedge clk_sys_i);
  endtask

  // --------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------
  task automatic test_regs();
    logic [31:0] r;
    logic e;
    for (int i = 0; i < 8; i++) begin
      chk_rd(8'(i * 4), 32'h0);
    end
    apb(1'b0, 8'h20, 32'h0, r, e);
    chk({31'h0, e}, 32'h1, "unmapped error");
    chk(r, 32'h0, "unmapped data");
    wr(bcx_pkg::ADDR_STACK_TOP, 32'h1234);
    chk_rd(bcx_pkg::ADDR_STACK_TOP, 32'h0);
    $display("test regs done");
  endtask

  task automatic test_run_main();
    u_mem.pmem[0] = 16'h7810;
    u_mem.pmem[1] = 16'h7f20;
    u_mem.pmem[2] = 16'h7080;
    u_mem.pmem[3] = 16'he005;
    u_mem.pmem[4] = 16'he403;
    u_mem.pmem[5] = 16'h6a30;
    u_mem.pmem[8] = 16'h6b40;
    u_mem.pmem[9] = 16'he07f;
    u_mem.pmem[10'h089] = 16'hed00;
    u_mem.pmem[10'h08a] = 16'hf001;
    u_mem.pmem[10'h100] = 16'he0ff;
    u_mem.dmem[12'h010] = 8'h75;
    u_mem.dmem[12'h220] = 8'h0f;
    u_mem.dmem[12'hf80] = 8'h01;
    u_mem.dmem[12'h030] = 8'hee;
    u_mem.dmem[12'h240] = 8'haa;
    wr(bcx_pkg::ADDR_BANK_SEL, 32'h2);
    wr(bcx_pkg::ADDR_WREG, 32'h5a);
    wr(bcx_pkg::ADDR_FLAGS, 32'h08);
    we_q.delete();
    pushes = 0;
    wr(bcx_pkg::ADDR_CTRL, 32'h1);
    repeat (100) @(posedge clk_sys_i);
    halt();
    chk({24'h0, u_mem.dmem[12'h010]}, 32'h65, "invert bit 4");
    chk({24'h0, u_mem.dmem[12'h220]}, 32'h8f, "invert banked");
    chk({24'h0, u_mem.dmem[12'hf80]}, 32'h00, "access hi bank");
    chk({24'h0, u_mem.dmem[12'h030]}, 32'hee, "discarded word");
    chk({24'h0, u_mem.dmem[12'h240]}, 32'h00, "clear");
    chk(32'(we_q.size()), 32'h4, "write count");
    if (we_q.size() == 4) begin
      chk(32'(we_q[1] - we_q[0]), 32'h4, "invert spacing");
      chk(32'(we_q[2] - we_q[1]), 32'h4, "invert spacing");
      chk(32'(we_q[3] - we_q[2]), 32'h10, "branch cycles");
    end
    chk_rd(bcx_pkg::ADDR_FLAGS, 32'h0c);
    chk({11'h0, stack_top_o}, 32'h116, "return address");
    chk(32'(pushes), 32'h1, "push count");
    chk_rd(bcx_pkg::ADDR_STACK_TOP, 32'h116);
    chk_rd(bcx_pkg::ADDR_SHADOW, 32'h4c5a);
    // loop at 200h: the register holds the loop or the word after it
    chk({31'h0, u_dut.pmem_req_o.addr[20:2] == 19'h080}, 32'h1,
        "call and branch target");
    $display("test run main done");
  endtask

  task automatic test_run_ext();
    // untaken overflow branch would skip the indexed clear if it jumped
    u_mem.pmem[10'h180] = 16'h7205;
    u_mem.pmem[10'h181] = 16'he401;
    u_mem.pmem[10'h182] = 16'h6a06;
    u_mem.pmem[10'h183] = 16'hec00;
    u_mem.pmem[10'h184] = 16'hf001;
    u_mem.dmem[12'h106] = 8'h55;
    wr(bcx_pkg::ADDR_WREG, 32'h33);
    wr(bcx_pkg::ADDR_FLAGS, 32'h0);
    wr(bcx_pkg::ADDR_INDEX_BASE, 32'h100);
    wr(bcx_pkg::ADDR_PC, 32'h300);
    chk_rd(bcx_pkg::ADDR_PC, 32'h300);
    wr(bcx_pkg::ADDR_CTRL, 32'h3);
    repeat (60) @(posedge clk_sys_i);
    halt();
    chk({24'h0, u_mem.dmem[12'h105]}, 32'h02, "indexed invert");
    chk({24'h0, u_mem.dmem[12'h106]}, 32'h00, "indexed clear");
    chk_rd(bcx_pkg::ADDR_FLAGS, 32'h04);
    chk_rd(bcx_pkg::ADDR_STACK_TOP, 32'h30a);
    chk_rd(bcx_pkg::ADDR_SHADOW, 32'h4c5a);
    chk_rd(bcx_pkg::ADDR_WREG, 32'h33);
    $display("test run ext done");
  endtask

  // --------------------------------------------------------------------
  // verdict and sequence
  // --------------------------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys_i);
    fails++;
    $display("[ERR] %0t watchdog expired", $time);
    print_verdict();
  end

  initial begin
    repeat (3) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    test_regs();
    test_run_main();
    test_run_ext();
    print_verdict();
  end
endmodule
`default_nettype wire
